/* common/iic_defs.svh */
`ifndef IIC_DEFS_SVH
`define IIC_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define IIC_A_CTRL    4'h0
`define IIC_A_STAT    4'h4
`define IIC_A_DATA    4'h8
`define IIC_A_DIV     4'hC

// Control register bit positions
`define IIC_C_EN      0
`define IIC_C_MASTER  1
`define IIC_C_TX      2
`define IIC_C_WAIT    3
`define IIC_C_DBL     4
`define IIC_C_EXT     5
`define IIC_C_NOACK   6

// Status register bit positions
`define IIC_S_BUSY    0
`define IIC_S_QUAL    1
`define IIC_S_XFER    2
`define IIC_S_SCL     3
`define IIC_S_SDA     4
`define IIC_S_ACK     5

// Reset values and divider minimum
`define IIC_CTRL_RST  7'h00
`define IIC_DIV_RST   8'h10
`define IIC_DIV_MIN   8'h02

////////////////////////////////////////////////////////////////////////////////
// Clock-line sampling windows, in tenths of a link clock cycle
`define IIC_WIN0_X10  75
`define IIC_WIN1_X10  175
`define IIC_WIN2_X10  375
// Least time rounds up to whole cycles
`define IIC_WIN_CYC(x10) (((x10) + 9) / 10)

`endif

/* common/iic_pkg.sv */
package iic_pkg;

  // Link-side sequencer states
  typedef enum logic [2:0] {
    L_IDLE,
    L_START,
    L_LOW,
    L_HIGH,
    L_HOLD,
    L_WAIT,
    L_EDGE
  } iic_lstate_e;

endpackage

/* rtl/iic_sync.sv */
`timescale 1ns/100ps

// Two-flop level synchroniser, cleared to zero
module iic_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // Only the second stage is visible outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* rtl/iic_filt.sv */
`timescale 1ns/100ps

// Pin synchroniser followed by a two-latch match filter
module iic_filt (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic s1, s2, la, lb, next_q;

  // Idle bus level is high, so everything resets high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      la <= 1'b1;
      lb <= 1'b1;
      q  <= 1'b1;
    end else begin
      s1 <= d;
      s2 <= s1;
      la <= s2;
      lb <= la;
      q  <= next_q;
    end
  end

  // Forward only when both latches agree, else hold
  always_comb begin
    next_q = (la == lb) ? lb : q;
  end

  property p_filt_agree;
    @(posedge clk) disable iff (!rst_n)
      (q != $past(q)) |-> $past(la == lb);
  endproperty
  a_filt_agree: assert property (p_filt_agree)
    else $error("filter output changed while latches disagreed");

endmodule

/* rtl/iic_master.sv */
`timescale 1ns/100ps
`include "iic_defs.svh"

module iic_master (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        lclk,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  localparam logic [5:0] WIN0 = 6'(`IIC_WIN_CYC(`IIC_WIN0_X10));
  localparam logic [5:0] WIN1 = 6'(`IIC_WIN_CYC(`IIC_WIN1_X10));
  localparam logic [5:0] WIN2 = 6'(`IIC_WIN_CYC(`IIC_WIN2_X10));

  // Sampling window chosen by doubler and rate extend
  function automatic logic [5:0] win_lim(input logic dbl, input logic ext);
    logic [5:0] r;
    case ({dbl, ext})
      2'b00:   r = WIN0;
      2'b11:   r = WIN2;
      default: r = WIN1;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // System-clock side: bus slave and registers

  logic [6:0]  ctrl, next_ctrl;
  logic [7:0]  div, next_div;
  logic [7:0]  txd, next_txd;
  logic [7:0]  rxd, next_rxd;
  logic        flag, next_flag;
  logic        ackr, next_ackr;
  logic        go_t, next_go_t;
  logic        st_t, next_st_t;
  logic        sp_t, next_sp_t;
  logic        ct_t, next_ct_t;
  logic        dp_wr, next_dp_wr;
  logic [3:0]  dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;
  logic        dn_d, wt_d;
  logic [4:0]  s_h;
  logic        ap, rd_go, wr_go, done_ev, wait_ev;

  // Link-side state, declared here for the crossings
  logic [7:0]  rx;
  logic        ack;
  logic        done_t, wait_t, busy;
  logic        scl_f, sda_f;

  // Zero-wait slave, never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign ap      = hsel & htrans[1] & hready;
  assign done_ev = s_h[4] ^ dn_d;
  assign wait_ev = s_h[3] ^ wt_d;
  // Receive starts on the read address phase itself
  assign rd_go = ap & ~hwrite & (haddr[3:0] == `IIC_A_DATA)
               & ctrl[`IIC_C_EN] & ~ctrl[`IIC_C_TX];
  assign wr_go = dp_wr & (dp_addr == `IIC_A_DATA)
               & ctrl[`IIC_C_EN] & ctrl[`IIC_C_TX];

  // Link events and line levels into the system clock
  iic_sync #(.W(5)) u_l2h (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({done_t, wait_t, scl_f, sda_f, busy}),
    .q     (s_h)
  );

  // Register writes, commands and flag handling
  always_comb begin
    next_ctrl    = ctrl;
    next_div     = div;
    next_txd     = txd;
    next_rxd     = rxd;
    next_flag    = flag;
    next_ackr    = ackr;
    next_go_t    = go_t ^ (rd_go | wr_go);
    next_st_t    = st_t;
    next_sp_t    = sp_t;
    next_ct_t    = ct_t;
    next_dp_wr   = ap & hwrite;
    next_dp_addr = ap ? haddr[3:0] : dp_addr;
    next_hrdata  = hrdata;
    if (dp_wr) begin
      case (dp_addr)
        `IIC_A_CTRL: next_ctrl = hwdata[6:0];
        `IIC_A_DIV:  next_div = (hwdata[7:0] < `IIC_DIV_MIN) ? `IIC_DIV_MIN : hwdata[7:0];
        `IIC_A_DATA: next_txd = hwdata[7:0];
        `IIC_A_STAT: begin
          if (ctrl[`IIC_C_MASTER] && !hwdata[`IIC_S_QUAL]) begin
            if (!hwdata[`IIC_S_BUSY]) begin
              next_sp_t = ~sp_t;
            end else if (ctrl[`IIC_C_TX]) begin
              next_st_t = ~st_t;
            end
          end
          // Clearing the flag also releases a wait hold
          if (!hwdata[`IIC_S_XFER] && flag) begin
            next_flag = 1'b0;
            next_ct_t = ~ct_t;
          end
        end
        default: ;
      endcase
    end
    // Received byte is stable on the link side until the ninth clock of the next byte
    if (done_ev) begin
      next_rxd  = rx;
      next_ackr = ack;
    end
    // A set in the same cycle as a clear wins
    if (done_ev || wait_ev) begin
      next_flag = 1'b1;
    end
    if (ap && !hwrite) begin
      case (haddr[3:0])
        `IIC_A_CTRL: next_hrdata = {25'h0000000, ctrl};
        `IIC_A_STAT: next_hrdata = {26'h0000000, ackr, s_h[1], s_h[2], flag, 1'b0, s_h[0]};
        `IIC_A_DATA: next_hrdata = {24'h000000, rxd};
        `IIC_A_DIV:  next_hrdata = {24'h000000, div};
        default:     next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= `IIC_CTRL_RST;
      div     <= `IIC_DIV_RST;
      txd     <= 8'h00;
      rxd     <= 8'h00;
      flag    <= 1'b0;
      ackr    <= 1'b0;
      go_t    <= 1'b0;
      st_t    <= 1'b0;
      sp_t    <= 1'b0;
      ct_t    <= 1'b0;
      dp_wr   <= 1'b0;
      dp_addr <= 4'h0;
      hrdata  <= 32'h00000000;
      dn_d    <= 1'b0;
      wt_d    <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      div     <= next_div;
      txd     <= next_txd;
      rxd     <= next_rxd;
      flag    <= next_flag;
      ackr    <= next_ackr;
      go_t    <= next_go_t;
      st_t    <= next_st_t;
      sp_t    <= next_sp_t;
      ct_t    <= next_ct_t;
      dp_wr   <= next_dp_wr;
      dp_addr <= next_dp_addr;
      hrdata  <= next_hrdata;
      dn_d    <= s_h[4];
      wt_d    <= s_h[3];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link-clock side: pin filters and bit sequencer

  logic        lrst_n;
  logic [16:0] ls;
  logic [3:0]  pa;
  logic        ev_go, ev_st, ev_sp, ev_ct;
  logic        l_en, l_tx, l_wait;
  logic [5:0]  lim;
  logic [7:0]  h;

  iic_pkg::iic_lstate_e state, next_state;
  logic [7:0]  cnt, next_cnt;
  logic [5:0]  win, next_win;
  logic [3:0]  bitn, next_bitn;
  logic [8:0]  sh, next_sh;
  logic        scl_drv, next_scl_drv;
  logic        sda_drv, next_sda_drv;
  logic [7:0]  next_rx;
  logic        next_ack, next_done_t, next_wait_t, next_busy;
  logic        phase, next_phase;
  logic        is_stop, next_is_stop;
  logic        scl_p, sda_p;

  // Release of the link reset follows the link clock
  iic_sync #(.W(1)) u_rst (
    .clk   (lclk),
    .rst_n (hresetn),
    .d     (1'b1),
    .q     (lrst_n)
  );

  // Toggles and quasi-static settings; byte and no-ack are held stable
  iic_sync #(.W(17)) u_h2l (
    .clk   (lclk),
    .rst_n (lrst_n),
    .d     ({go_t, st_t, sp_t, ct_t, ctrl[`IIC_C_EN], ctrl[`IIC_C_TX],
             ctrl[`IIC_C_WAIT], ctrl[`IIC_C_DBL], ctrl[`IIC_C_EXT], div}),
    .q     (ls)
  );

  iic_filt u_fscl (
    .clk   (lclk),
    .rst_n (lrst_n),
    .d     (scl_i),
    .q     (scl_f)
  );

  iic_filt u_fsda (
    .clk   (lclk),
    .rst_n (lrst_n),
    .d     (sda_i),
    .q     (sda_f)
  );

  assign {ev_go, ev_st, ev_sp, ev_ct} = ls[16:13] ^ pa;
  assign l_en   = ls[12];
  assign l_tx   = ls[11];
  assign l_wait = ls[10];
  assign lim    = win_lim(ls[9], ls[8]);
  assign h      = ls[7:0];

  // Open drain: output data always low, enable pulls the line
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_drv;
  assign sda_oe = sda_drv;

  // Bit sequencer and bus start/stop watcher
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_win     = win;
    next_bitn    = bitn;
    next_sh      = sh;
    next_scl_drv = scl_drv;
    next_sda_drv = sda_drv;
    next_rx      = rx;
    next_ack     = ack;
    next_done_t  = done_t;
    next_wait_t  = wait_t;
    next_phase   = phase;
    next_is_stop = is_stop;
    next_busy    = busy;
    if (scl_f && scl_p && sda_p && !sda_f) begin
      next_busy = 1'b1;
    end else if (scl_f && scl_p && !sda_p && sda_f) begin
      next_busy = 1'b0;
    end
    case (state)
      iic_pkg::L_IDLE: begin
        next_scl_drv = 1'b0;
        next_sda_drv = 1'b0;
        if (ev_st && l_en && !busy) begin
          next_sda_drv = 1'b1;
          next_cnt     = 8'h00;
          next_state   = iic_pkg::L_START;
        end
      end
      iic_pkg::L_START: begin
        next_cnt = cnt + 8'h01;
        if (cnt >= h) begin
          next_scl_drv = 1'b1;
          next_state   = iic_pkg::L_HOLD;
        end
      end
      iic_pkg::L_HOLD: begin
        // Clock stays low until software moves on
        next_scl_drv = 1'b1;
        if (ev_go) begin
          next_sh    = l_tx ? {txd, 1'b1} : {8'hFF, ctrl[`IIC_C_NOACK]};
          next_bitn  = 4'h0;
          next_cnt   = 8'h00;
          next_state = iic_pkg::L_LOW;
        end else if ((ev_sp || ev_st) && !scl_f) begin
          // Only once the clock is truly low, so data never moves under a high clock
          next_is_stop = ev_sp;
          next_sda_drv = ev_sp;
          next_phase   = 1'b0;
          next_cnt     = 8'h00;
          next_state   = iic_pkg::L_EDGE;
        end
      end
      iic_pkg::L_LOW: begin
        next_sda_drv = ~sh[8];
        next_cnt     = cnt + 8'h01;
        if (cnt >= h) begin
          next_scl_drv = 1'b0;
          next_cnt     = 8'h00;
          next_win     = 6'h00;
          next_state   = iic_pkg::L_HIGH;
        end
      end
      iic_pkg::L_HIGH: begin
        // High time stalls once the window passes with the line still low
        if (scl_f || win < lim) begin
          next_cnt = cnt + 8'h01;
        end
        if (!scl_f && win < lim) begin
          next_win = win + 6'h01;
        end
        if (scl_f && !scl_p && bitn == 4'h8) begin
          next_done_t = ~done_t;
          next_rx     = sh[7:0];
          next_ack    = sda_f;
        end
        if (scl_f && cnt >= h) begin
          // Lowering is timed from the filtered line, so it can lag
          next_scl_drv = 1'b1;
          next_sh      = {sh[7:0], sda_f};
          next_bitn    = bitn + 4'h1;
          next_cnt     = 8'h00;
          if (bitn == 4'h8) begin
            next_sda_drv = 1'b0;
            next_state   = iic_pkg::L_HOLD;
          end else if (bitn == 4'h7 && l_wait) begin
            next_wait_t = ~wait_t;
            next_state  = iic_pkg::L_WAIT;
          end else begin
            next_state = iic_pkg::L_LOW;
          end
        end
      end
      iic_pkg::L_WAIT: begin
        if (ev_ct && !scl_f) begin
          next_state = iic_pkg::L_LOW;
        end
      end
      iic_pkg::L_EDGE: begin
        if (!phase) begin
          next_cnt = cnt + 8'h01;
          if (cnt >= h) begin
            next_scl_drv = 1'b0;
            next_phase   = 1'b1;
            next_cnt     = 8'h00;
          end
        end else if (scl_f) begin
          next_cnt = cnt + 8'h01;
          if (cnt >= h) begin
            next_cnt     = 8'h00;
            next_sda_drv = ~is_stop;
            next_state   = is_stop ? iic_pkg::L_IDLE : iic_pkg::L_START;
          end
        end
      end
      default: next_state = iic_pkg::L_IDLE;
    endcase
    // Disabling the interface drops the bus at once
    if (!l_en) begin
      next_state   = iic_pkg::L_IDLE;
      next_scl_drv = 1'b0;
      next_sda_drv = 1'b0;
    end
  end

  always_ff @(posedge lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      state   <= iic_pkg::L_IDLE;
      cnt     <= 8'h00;
      win     <= 6'h00;
      bitn    <= 4'h0;
      sh      <= 9'h000;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
      rx      <= 8'h00;
      ack     <= 1'b0;
      done_t  <= 1'b0;
      wait_t  <= 1'b0;
      busy    <= 1'b0;
      phase   <= 1'b0;
      is_stop <= 1'b0;
      pa      <= 4'h0;
      scl_p   <= 1'b1;
      sda_p   <= 1'b1;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      win     <= next_win;
      bitn    <= next_bitn;
      sh      <= next_sh;
      scl_drv <= next_scl_drv;
      sda_drv <= next_sda_drv;
      rx      <= next_rx;
      ack     <= next_ack;
      done_t  <= next_done_t;
      wait_t  <= next_wait_t;
      busy    <= next_busy;
      phase   <= next_phase;
      is_stop <= next_is_stop;
      pa      <= ls[16:13];
      scl_p   <= scl_f;
      sda_p   <= sda_f;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_go_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_go |=> (go_t != $past(go_t));
  endproperty
  a_go_write: assert property (p_go_write)
    else $error("data write did not launch a byte");

  property p_stop_cmd;
    @(posedge hclk) disable iff (!hresetn)
      (dp_wr && dp_addr == `IIC_A_STAT && ctrl[`IIC_C_MASTER]
       && hwdata[1:0] == 2'b00) |=> (sp_t != $past(sp_t));
  endproperty
  a_stop_cmd: assert property (p_stop_cmd)
    else $error("stop command not forwarded");

  property p_start_cmd;
    @(posedge hclk) disable iff (!hresetn)
      (dp_wr && dp_addr == `IIC_A_STAT && ctrl[`IIC_C_MASTER] && ctrl[`IIC_C_TX]
       && hwdata[1:0] == 2'b01) |=> (st_t != $past(st_t));
  endproperty
  a_start_cmd: assert property (p_start_cmd)
    else $error("start command not forwarded");

  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn)
      (done_ev || wait_ev) |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("transfer flag lost its set");

  property p_hold_low;
    @(posedge lclk) disable iff (!lrst_n)
      (state == iic_pkg::L_HOLD && l_en) |=> scl_oe;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("clock not held low after byte");

  property p_stretch;
    @(posedge lclk) disable iff (!lrst_n)
      (state == iic_pkg::L_HIGH && !scl_f && win >= win_lim(ls[9], ls[8])
       && $stable(ls)) |=> (cnt == $past(cnt));
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("high period not extended");

  property p_wait_clock_low;
    @(posedge lclk) disable iff (!lrst_n)
      (state == iic_pkg::L_WAIT && scl_f && l_en) |=> (state == iic_pkg::L_WAIT);
  endproperty
  a_wait_clock_low: assert property (p_wait_clock_low)
    else $error("wait released while clock high");

  property p_stop_guard;
    @(posedge lclk) disable iff (!lrst_n)
      (state == iic_pkg::L_HOLD && scl_f && !ev_go && l_en)
      |=> (state == iic_pkg::L_HOLD) && $stable(sda_oe);
  endproperty
  a_stop_guard: assert property (p_stop_guard)
    else $error("stop issued before clock fell");

  property p_open_drain;
    @(posedge lclk) disable iff (!lrst_n)
      !l_en |=> (!scl_oe && !sda_oe && !scl_o && !sda_o);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line driven high");

endmodule

/* tb/iic_slave_model.sv */
`timescale 1ns/100ps

// Behavioural slave on the wired bus; releases lines to the pull-up
module iic_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       tx_mode,
  input  wire logic [7:0] tx_byte,
  input  var  int         stretch_ns,
  output logic            scl_low,
  output logic            sda_low,
  output logic [7:0]      rx_byte,
  output int              n_start,
  output int              n_stop
);
  logic       active = 1'b0;
  logic       quiet  = 1'b0;
  logic       mack   = 1'b0;
  logic [3:0] bitcnt = 4'h0;
  logic [3:0] slot   = 4'h0;

  // Counters and outputs start clean
  initial begin
    scl_low = 1'b0;
    rx_byte = 8'h00;
    n_start = 0;
    n_stop  = 0;
  end

  ////////////////////////////////////////
  // Framing seen on the wired lines
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      n_start++;
      {active, quiet, mack, bitcnt, slot} = {3'b100, 8'h00};
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      n_stop++;
      active = 1'b0;
    end
  end

  // Sample on the rise; the ninth bit is the acknowledge
  always @(posedge scl) begin
    if (active) begin
      if (bitcnt < 4'h8) rx_byte = {rx_byte[6:0], sda};
      else mack = sda;
      bitcnt = bitcnt + 4'h1;
    end
  end

  // Slot moves only while scl is low, so our drive never fakes framing
  always @(negedge scl) begin
    if (active) begin
      if (bitcnt == 4'h9) bitcnt = 4'h0;
      if (bitcnt == 4'h0 && tx_mode && mack) quiet = 1'b1;
      slot = bitcnt;
    end
  end

  // Slow slave: hold scl low after each fall, longer than any window
  always @(negedge scl) begin
    if (active && stretch_ns > 0) begin
      scl_low = 1'b1;
      #(stretch_ns);
      scl_low = 1'b0;
    end
  end

  // Data bits when sending, acknowledge when receiving
  always_comb begin
    if (!active || quiet) sda_low = 1'b0;
    else if (slot < 4'h8) sda_low = tx_mode && !tx_byte[3'h7 - slot[2:0]];
    else sda_low = (slot == 4'h8) && !tx_mode;
  end
endmodule

/* tb/test_i2c_master_bus_sequencing.sv */
`timescale 1ns/100ps
`include "iic_defs.svh"

module test_i2c_master_bus_sequencing;
  localparam int          DIV      = 4;
  localparam logic [31:0] IDLE     = 32'h1 << `IIC_S_SCL | 32'h1 << `IIC_S_SDA;
  localparam logic [31:0] CTL [5]  = '{32'h27, 32'h07, 32'h17, 32'h37, 32'h0F};
  // Stretch ends between link clock rises, so the release never races a sample
  localparam int          ST [5]   = '{0, 303, 303, 303, 303};
  logic                   hclk     = 1'b0;
  logic                   lclk     = 1'b0;
  logic                   hresetn;
  logic                   hsel;
  logic                   hwrite;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [31:0]            haddr;
  logic [31:0]            hwdata;
  logic [31:0]            hrdata;
  logic                   hreadyout, hresp;
  logic                   scl_o, scl_oe, sda_o, sda_oe;
  logic                   scl_low, sda_low, tx_mode;
  logic [7:0]             tx_byte, rx_byte;
  int                     stretch_ns, n_start, n_stop, n_mismatch, checked;
  realtime                t_rise, hmin;
  wire                    scl_w = !((scl_oe && !scl_o) || scl_low);
  wire                    sda_w = !((sda_oe && !sda_o) || sda_low);

  // System clock, and a link clock offset so edges never coincide
  always #20 hclk = !hclk;
  initial #1.3 forever #3 lclk = !lclk;

  iic_master i_iic_master (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .lclk(lclk), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));

  iic_slave_model i_iic_slave_model (
    .scl(scl_w), .sda(sda_w), .tx_mode(tx_mode), .tx_byte(tx_byte),
    .stretch_ns(stretch_ns), .scl_low(scl_low), .sda_low(sda_low),
    .rx_byte(rx_byte), .n_start(n_start), .n_stop(n_stop));

  // Shortest scl high time on the wire
  always @(posedge scl_w) t_rise = $realtime;
  always @(negedge scl_w) if ($realtime - t_rise < hmin) hmin = $realtime - t_rise;

  ////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  // One single transfer; the wait has no bound, the watchdog cuts a hang
  task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {28'h0000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    if (w) hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string w);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(w, e, x);
  endtask

  task automatic poll(input int b, input logic v);
    logic [31:0] s;
    do ahb(1'b0, `IIC_A_STAT, 32'h0, s); while (s[b] !== v);
  endtask

  task automatic put(input logic [7:0] b);
    wr(`IIC_A_DATA, {24'h000000, b});
    poll(`IIC_S_XFER, 1'b1);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Whole run is a few hundred microseconds; 2 ms means a hang
  initial begin
    #2_000_000;
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    logic [31:0] s;
    int          n0;
    int          n1;
    {hresetn, hsel, hwrite, tx_mode} = 4'h0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'h2};
    {tx_byte, stretch_ns, n_mismatch, checked} = {8'h00, 96'h0};
    t_rise = 0.0;
    hmin   = 0.0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (10) @(posedge hclk);
    rdc(`IIC_A_CTRL, {25'h0, `IIC_CTRL_RST}, "ctrl reset");
    rdc(`IIC_A_DIV, {24'h0, `IIC_DIV_RST}, "div reset");
    rdc(`IIC_A_STAT, IDLE, "idle status");
    wr(`IIC_A_DIV, 32'h0);
    rdc(`IIC_A_DIV, {24'h0, `IIC_DIV_MIN}, "div clamp");
    wr(`IIC_A_DIV, DIV);
    $display("test registers done");
    // One prompt run, then each clock-line window stretched, then wait mode
    for (int i = 0; i < 5; i++) begin
      wr(`IIC_A_CTRL, CTL[i]);
      stretch_ns = ST[i];
      n0 = n_start;
      n1 = n_stop;
      wr(`IIC_A_STAT, 32'h1);
      poll(`IIC_S_BUSY, 1'b1);
      chk("start on wire", n0 + 1, n_start);
      ahb(1'b0, `IIC_A_DATA, 32'h0, s);
      repeat (300) @(posedge hclk);
      rdc(`IIC_A_STAT, 32'h1, "no byte on read while sending");
      hmin = 1.0e6;
      put(8'(8'hA0 + i));
      chk("byte on wire", 32'hA0 + i, {24'h0, rx_byte});
      chk("scl high time", 32'h1, {31'h0, hmin >= (DIV + 1) * 6.0});
      ahb(1'b0, `IIC_A_STAT, 32'h0, s);
      chk("held after byte", 32'h5, s & 32'h2F);
      wr(`IIC_A_STAT, 32'h2);
      repeat (400) @(posedge hclk);
      wr(`IIC_A_STAT, 32'h0);
      poll(`IIC_S_BUSY, 1'b0);
      chk("single start", n0 + 1, n_start);
      chk("single stop", n1 + 1, n_stop);
      rdc(`IIC_A_STAT, IDLE, "lines released");
      chk("drivers off", 32'h0, {30'h0, scl_oe, sda_oe});
      $display("test session %0d done", i);
    end
    // Send one byte, receive one byte, turn to transmit, then a repeated start
    stretch_ns = 0;
    wr(`IIC_A_CTRL, 32'h07);
    wr(`IIC_A_STAT, 32'h1);
    poll(`IIC_S_BUSY, 1'b1);
    put(8'h81);
    {tx_mode, tx_byte} = {1'b1, 8'h3C};
    wr(`IIC_A_CTRL, 32'h43);
    wr(`IIC_A_STAT, 32'h2);
    ahb(1'b0, `IIC_A_DATA, 32'h0, s);
    poll(`IIC_S_XFER, 1'b1);
    wr(`IIC_A_CTRL, 32'h47);
    rdc(`IIC_A_DATA, 32'h3C, "received byte");
    tx_mode = 1'b0;
    wr(`IIC_A_STAT, 32'h2);
    n0 = n_start;
    wr(`IIC_A_STAT, 32'h1);
    while (n_start == n0) @(posedge hclk);
    put(8'h5A);
    chk("byte after repeated start", 32'h5A, {24'h0, rx_byte});
    wr(`IIC_A_STAT, 32'h2);
    wr(`IIC_A_STAT, 32'h0);
    poll(`IIC_S_BUSY, 1'b0);
    // Bare start then stop, only once both lines read low
    n1 = n_stop;
    wr(`IIC_A_STAT, 32'h1);
    poll(`IIC_S_SCL, 1'b0);
    rdc(`IIC_A_STAT, 32'h1, "both lines low before stop");
    wr(`IIC_A_STAT, 32'h0);
    poll(`IIC_S_BUSY, 1'b0);
    chk("stop after bare start", n1 + 1, n_stop);
    wr(`IIC_A_CTRL, 32'h0);
    rdc(`IIC_A_CTRL, 32'h0, "master cleared");
    $display("test receive and repeated start done");
    stop_test();
  end
endmodule
